/* File: design/auto_clock.sv */
`include "twowire_params.svh"

module auto_clock #(
    parameter int DELAY = `AUTO_DELAY_CYCLES,
    parameter int HIGH = `AUTO_HIGH_CYCLES,
    parameter int PAUSE = `AUTO_PAUSE_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // control
    input wire logic i_start,
    input wire logic i_scl_level,
    // pulse out
    output logic o_pulse
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (DELAY < 1 || HIGH < 1 || PAUSE < 1 || PAUSE >= HIGH) begin : g_chk
        $error("auto_clock: bad timing parameters");
    end

    localparam int CW = $clog2(DELAY + HIGH + 1);

    twowire_pkg::auto_state_t state_q;
    twowire_pkg::auto_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic pulse_q;
    logic delay_end;
    logic high_end;
    logic held;

    // ****************************************************************
    // sequencing
    // ****************************************************************
    assign delay_end = cnt_q == CW'(DELAY - 1);
    assign high_end = cnt_q == CW'(HIGH - 1);
    // line held low by someone: wait once past the pause point
    assign held = (cnt_q >= CW'(PAUSE)) && !i_scl_level;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + CW'(1);
        unique case (state_q)
            twowire_pkg::AC_IDLE: begin
                cnt_d = '0;
                if (i_start) begin
                    state_d = twowire_pkg::AC_DELAY;
                end
            end
            twowire_pkg::AC_DELAY: begin
                if (delay_end) begin
                    state_d = twowire_pkg::AC_HIGH;
                    cnt_d = '0;
                end
            end
            twowire_pkg::AC_HIGH: begin
                if (held) begin
                    cnt_d = cnt_q;
                end else if (high_end) begin
                    state_d = twowire_pkg::AC_IDLE;
                    cnt_d = '0;
                end
            end
            // unused state code falls back to idle
            default: begin
                state_d = twowire_pkg::AC_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= twowire_pkg::AC_IDLE;
            cnt_q <= '0;
            pulse_q <= 1'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pulse_q <= state_d == twowire_pkg::AC_HIGH;
        end
    end

    assign o_pulse = pulse_q;

endmodule : auto_clock

/* File: design/bit_bus_control.sv */
// Behaviour
// - scl rise latches filtered sda into bit 7
// - bit 7 shared; control access no auto-clock
// - scl out is clock-out OR auto pulse
// - scl is wired, anyone may pull low
// - rise flag at least 8 periods after rise
// - bit 5 set by filtered scl rise
// - bit5 write-0 or data access clears flags
// - busy set by start, cleared by stop
// - read-done needs rise, scl low, busy, no start
// - write-done also needs no arbitration loss
// - stretch-enable stretches every low; software clears
// - hidden stretch flag holds scl low, set falling
// - start sets stretch; data access clears it
// - interface enable gates start detection, stretching
// - auto pulse: delay 28, high 100, pause 20
// - data access clears flags, starts auto-clock if clock-out is 0
// - start flag set on next scl fall
`include "twowire_params.svh"

module bit_bus_control (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // register access
    input wire twowire_pkg::sfr_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // serial clock pin
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe,
    // serial data pin
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // start event to the interrupt system
    output logic o_start_flag
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic scl_f;
    logic scl_rise;
    logic scl_fall;
    logic sda_f;
    logic sda_rise;
    logic sda_fall;
    logic auto_pulse;

    logic data_out_q;
    logic data_in_q;
    logic clock_out_q;
    logic clock_rise_q;
    logic busy_q;
    logic arb_lost_q;
    logic stretch_en_q;
    logic if_en_q;
    logic start_seen_q;
    logic start_flag_q;
    logic stretch_act_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    logic ctrl_wr;
    logic ctrl_rd;
    logic data_acc;
    logic data_wr;
    logic rise_clr;
    logic start_cond;
    logic stop_cond;
    logic start_fall;
    logic read_done;
    logic write_done;
    logic auto_go;
    logic scl_low_req;
    logic [7:0] ctrl_view;
    logic [7:0] data_view;

    // ****************************************************************
    // line filters
    // ****************************************************************
    line_filter #(
        .STABLE(`FILTER_CYCLES)
    ) u_scl_filter (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_line(i_scl),
        .o_level(scl_f),
        .o_rise(scl_rise),
        .o_fall(scl_fall)
    );

    line_filter #(
        .STABLE(`FILTER_CYCLES)
    ) u_sda_filter (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_line(i_sda),
        .o_level(sda_f),
        .o_rise(sda_rise),
        .o_fall(sda_fall)
    );

    // ****************************************************************
    // access decode
    // ****************************************************************
    assign ctrl_wr = i_req.wr && !i_req.sel_data;
    assign ctrl_rd = i_req.rd && !i_req.sel_data;
    assign data_acc = (i_req.rd || i_req.wr) && i_req.sel_data;
    assign data_wr = i_req.wr && i_req.sel_data;
    assign rise_clr = data_acc || (ctrl_wr && !i_req.wdata[`CS_RISE_BIT]);

    // ****************************************************************
    // bus conditions
    // ****************************************************************
    // start detection gated
    assign start_cond = if_en_q && sda_fall && scl_f;
    assign stop_cond = sda_rise && scl_f;
    // start flag waits for scl fall
    assign start_fall = start_seen_q && scl_fall;
    assign read_done = clock_rise_q && !scl_f && !start_flag_q && busy_q;
    assign write_done = read_done && !arb_lost_q;

    // ****************************************************************
    // auto-clock
    // ****************************************************************
    // only data access starts it
    assign auto_go = data_acc && !clock_out_q;

    auto_clock #(
        .DELAY(`AUTO_DELAY_CYCLES),
        .HIGH(`AUTO_HIGH_CYCLES),
        .PAUSE(`AUTO_PAUSE_CYCLES)
    ) u_auto_clock (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_start(auto_go),
        .i_scl_level(scl_f),
        .o_pulse(auto_pulse)
    );

    // ****************************************************************
    // line drive
    // ****************************************************************
    // clock-out ored with auto pulse
    assign scl_low_req = !(clock_out_q || auto_pulse) || stretch_act_q;

    // ****************************************************************
    // read views
    // ****************************************************************
    assign ctrl_view = {data_in_q, scl_f, clock_rise_q, busy_q, read_done, write_done,
                        stretch_en_q, if_en_q};
    assign data_view = {data_in_q, 7'h00};

    // ****************************************************************
    // data bit and clock-out bit
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            data_out_q <= `RST_DATA_OUT;
            clock_out_q <= `RST_CLOCK_OUT;
        end else begin
            // both registers write one data bit
            if (i_req.wr) begin
                data_out_q <= i_req.wdata[`CS_DATA_BIT];
            end
            if (ctrl_wr) begin
                clock_out_q <= i_req.wdata[`CS_CLK_BIT];
            end
        end
    end

    // ****************************************************************
    // received bit and arbitration
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            data_in_q <= 1'h1;
            arb_lost_q <= 1'h0;
        end else begin
            if (scl_rise) begin
                data_in_q <= sda_f;
            end
            if (scl_rise && data_out_q && !sda_f) begin
                arb_lost_q <= 1'h1;
            end else if (rise_clr) begin
                arb_lost_q <= 1'h0;
            end
        end
    end

    // ****************************************************************
    // rise flag
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            clock_rise_q <= 1'h0;
        end else begin
            // filter delays rise by 8 periods
            if (scl_rise) begin
                clock_rise_q <= 1'h1;
            end else if (rise_clr) begin
                clock_rise_q <= 1'h0;
            end
        end
    end

    // ****************************************************************
    // start and busy
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_q <= 1'h0;
            start_seen_q <= 1'h0;
            start_flag_q <= 1'h0;
        end else begin
            if (start_cond) begin
                busy_q <= 1'h1;
            end else if (stop_cond || !if_en_q) begin
                busy_q <= 1'h0;
            end
            if (start_cond) begin
                start_seen_q <= 1'h1;
            end else if (scl_fall || stop_cond || !if_en_q) begin
                start_seen_q <= 1'h0;
            end
            if (start_fall && if_en_q) begin
                start_flag_q <= 1'h1;
            end else if (data_acc || !if_en_q) begin
                start_flag_q <= 1'h0;
            end
        end
    end

    // ****************************************************************
    // stretching
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            stretch_en_q <= `RST_STRETCH_EN;
            if_en_q <= `RST_IF_EN;
            stretch_act_q <= 1'h0;
        end else begin
            if (ctrl_wr) begin
                stretch_en_q <= i_req.wdata[`CS_STRETCH_BIT];
                if_en_q <= i_req.wdata[`CS_ENABLE_BIT];
            end
            if (if_en_q && ((scl_fall && stretch_en_q) || start_fall)) begin
                stretch_act_q <= 1'h1;
            end else if (data_acc || !if_en_q) begin
                stretch_act_q <= 1'h0;
            end
        end
    end

    // ****************************************************************
    // pin drive and read data
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_oe_q <= 1'h0;
            sda_oe_q <= 1'h0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'h0;
        end else begin
            scl_oe_q <= scl_low_req;
            sda_oe_q <= !data_out_q;
            rvalid_q <= i_req.rd;
            if (i_req.rd) begin
                rdata_q <= i_req.sel_data ? data_view : ctrl_view;
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_scl_o = 1'h0 & scl_oe_q;
    assign o_sda_o = 1'h0 & sda_oe_q;
    assign o_scl_oe = scl_oe_q;
    assign o_sda_oe = sda_oe_q;
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_start_flag = start_flag_q;

endmodule : bit_bus_control

/* File: design/line_filter.sv */
`include "twowire_params.svh"

module line_filter #(
    parameter int STABLE = `FILTER_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // raw pin level
    input wire logic i_line,
    // filtered level and edges
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (STABLE < 1) begin : g_chk
        $error("line_filter: STABLE must be at least 1");
    end

    localparam int CW = $clog2(STABLE + 1);

    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic rise_q;
    logic fall_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic differ;
    logic settled;

    // ****************************************************************
    // stability counting
    // ****************************************************************
    assign differ = sync2_q != level_q;
    assign settled = differ && (cnt_q == CW'(STABLE - 1));
    assign cnt_d = (!differ || settled) ? '0 : cnt_q + CW'(1);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_q <= 1'h1;
            sync2_q <= 1'h1;
            level_q <= 1'h1;
            rise_q <= 1'h0;
            fall_q <= 1'h0;
            cnt_q <= '0;
        end else begin
            sync1_q <= i_line;
            sync2_q <= sync1_q;
            cnt_q <= cnt_d;
            level_q <= settled ? sync2_q : level_q;
            rise_q <= settled && sync2_q;
            fall_q <= settled && !sync2_q;
        end
    end

    assign o_level = level_q;
    assign o_rise = rise_q;
    assign o_fall = fall_q;

endmodule : line_filter

/* File: design/twowire_params.svh */
`ifndef TWOWIRE_PARAMS_SVH
`define TWOWIRE_PARAMS_SVH

// ****************************************************************
// control/status bit positions
// ****************************************************************
`define CS_DATA_BIT 7
`define CS_CLK_BIT 6
`define CS_RISE_BIT 5
`define CS_BUSY_BIT 4
`define CS_RDONE_BIT 3
`define CS_WDONE_BIT 2
`define CS_STRETCH_BIT 1
`define CS_ENABLE_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define RST_DATA_OUT 1'h1
`define RST_CLOCK_OUT 1'h1
`define RST_STRETCH_EN 1'h0
`define RST_IF_EN 1'h0

// ****************************************************************
// timing, in oscillator periods, and oscillator periods per clock
// ****************************************************************
`define OSC_PER_CLK 1
`define FILTER_MIN_PER 8
`define SYNC_STAGES 2
`define FILTER_CYCLES (`FILTER_MIN_PER * `OSC_PER_CLK - `SYNC_STAGES)
`define AUTO_DELAY_PER 28
`define AUTO_HIGH_PER 100
`define AUTO_PAUSE_PER 20
`define AUTO_DELAY_CYCLES (`AUTO_DELAY_PER * `OSC_PER_CLK)
`define AUTO_HIGH_CYCLES (`AUTO_HIGH_PER * `OSC_PER_CLK)
`define AUTO_PAUSE_CYCLES (`AUTO_PAUSE_PER * `OSC_PER_CLK)

`endif

/* File: design/twowire_pkg.sv */
package twowire_pkg;

    // ****************************************************************
    // register access request
    // ****************************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic sel_data;
        logic [7:0] wdata;
    } sfr_req_t;

    // ****************************************************************
    // auto-clock sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        AC_IDLE,
        AC_DELAY,
        AC_HIGH
    } auto_state_t;

endpackage : twowire_pkg

/* File: verif/bit_bus_control_monitor.sv */
// ****************************************
// port checker
// ****************************************
module bit_bus_control_monitor (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // register access
    input wire twowire_pkg::sfr_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    // pins
    input wire logic i_scl,
    input wire logic o_scl_o,
    input wire logic o_scl_oe,
    input wire logic i_sda,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_start_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    wire rdc = i_req.rd && !i_req.sel_data;
    wire dacc = i_req.sel_data && (i_req.rd || i_req.wr);
    wire clr5 = i_req.wr && !i_req.sel_data && !i_req.wdata[7 - 2];
    a_scl_low_only: assert property (o_scl_o == 1'h0)
        else $error("scl driven high");
    a_sda_low_only: assert property (o_sda_o == 1'h0)
        else $error("sda driven high");
    a_rdone_needs: assert property (rdc |=> !o_rdata[3] ||
        (o_rdata[5] && !o_rdata[6] && o_rdata[4] && !$past(o_start_flag)))
        else $error("read done without its conditions");
    a_wdone_needs: assert property (rdc |=> !o_rdata[2] || o_rdata[3])
        else $error("write done without read conditions");
    a_flags_cleared: assert property ((clr5 || dacc) ##2 rdc |=>
        !o_rdata[5] && o_rdata[3:2] == 2'h0)
        else $error("rise or done flags not cleared");
    a_busy_needs_en: assert property (rdc |=> o_rdata[0] || !o_rdata[4])
        else $error("busy while disabled");
    a_start_needs_en: assert property (rdc |=> o_rdata[0] || !o_start_flag)
        else $error("start flag while disabled");
    a_start_cleared: assert property (dacc |=> !o_start_flag)
        else $error("start flag kept after data access");
    a_sda_drive: assert property (i_req.wr |-> ##2 o_sda_oe == !$past(i_req.wdata[7], 2))
        else $error("sda pull does not follow data bit");
endmodule : bit_bus_control_monitor

bind bit_bus_control bit_bus_control_monitor bit_bus_control_monitor_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_scl(i_scl), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
    .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_start_flag(o_start_flag)
);

/* File: verif/bit_bus_control_tb.sv */
// ****************************************
// bench
// ****************************************
module bit_bus_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys;
    logic i_rstn;
    twowire_pkg::sfr_req_t req;
    logic [7:0] rdata;
    logic rvalid, scl, sda, scl_o, scl_oe, sda_o, sda_oe, start_flag;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    logic [7:0] rdv;
    logic v;
    logic bad;

    bit_bus_control bit_bus_control_i (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
        .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_start_flag(start_flag)
    );
    bus_device_model bus_device_model_i (
        .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda)
    );

    initial begin
        i_clk_sys = 1'h0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) cyc <= cyc + 1;

    // received bit with rise, busy, read done; write done lost on a 0
    function automatic logic [7:0] bit_view(input logic b);
        return {b, 4'h7, b, 2'h1};
    endfunction : bit_view

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic idle(input int cnt);
        repeat (cnt) @(posedge i_clk_sys);
        #1;
    endtask : idle
    task automatic acc(input logic rd, input logic sel, input logic [7:0] wd);
        @(posedge i_clk_sys);
        req <= '{rd: rd, wr: !rd, sel_data: sel, wdata: wd};
        @(posedge i_clk_sys);
        req <= '0;
        #1;
        if (rd) begin
            rdv = rdata;
            chk("rvalid", 8'h01, rvalid);
        end
    endtask : acc
    task automatic steady(input int cnt, input logic lvl);
        bad = 1'h0;
        repeat (cnt) begin
            idle(1);
            if (scl_oe !== lvl) bad = 1'h1;
        end
    endtask : steady
    task automatic span(input logic lvl);
        n = 0;
        while (scl_oe === lvl && n < 300) begin
            idle(1);
            n++;
        end
    endtask : span
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        #1000000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        req = '0;
        i_rstn = 1'h0;
        void'($urandom(97843));
        repeat (16) @(posedge i_clk_sys);
        i_rstn <= 1'h1;
        acc(1'h1, 1'h0, 8'h00);
        chk("reset view", 8'h40, rdv & 8'h7f);
        acc(1'h0, 1'h0, 8'hc1);
        idle(4);
        chk("sda oe", 8'h00, sda_oe);
        chk("scl oe", 8'h00, scl_oe);
        bus_device_model_i.start_cond();
        idle(12);
        acc(1'h1, 1'h0, 8'h00);
        chk("busy", 8'h01, rdv[4]);
        chk("start flag", 8'h01, start_flag);
        chk("start stretch", 8'h01, scl_oe);
        acc(1'h1, 1'h1, 8'h00);
        chk("data view", 8'h00, rdv & 8'h7f);
        idle(3);
        chk("start clear", 8'h00, start_flag);
        chk("stretch end", 8'h00, scl_oe);
        for (int i = 0; i < 6; i++) begin
            v = 1'($urandom);
            bus_device_model_i.send_bit(v);
            idle(12);
            acc(1'h1, 1'h0, 8'h00);
            chk("bit view", bit_view(v), rdv);
            acc(i[0], i[0], 8'hc1);
            acc(1'h1, 1'h0, 8'h00);
            chk("flags clear", 8'h00, rdv & 8'h2c);
        end
        acc(1'h0, 1'h0, 8'h81);
        v = 1'($urandom);
        bus_device_model_i.drive(1'h0, !v);
        idle(12);
        acc(1'h0, 1'h0, 8'hc1);
        n = cyc;
        rdv = 8'h00;
        while (!rdv[5] && cyc - n < 40) acc(1'h1, 1'h0, 8'h00);
        chk("rise delay", 8'h01, cyc - n >= 8 && cyc - n < 40);
        chk("rx bit", v, rdv[7]);
        acc(1'h0, 1'h0, 8'h81);
        acc(1'h0, 1'h0, 8'hc3);
        idle(12);
        bus_device_model_i.drive(1'h1, 1'h0);
        idle(16);
        bus_device_model_i.drive(1'h0, 1'h0);
        idle(8);
        chk("held low", 8'h00, scl);
        acc(1'h1, 1'h0, 8'h00);
        chk("stretch en", 8'h01, rdv[1]);
        acc(1'h0, 1'h0, 8'h83);
        acc(1'h0, 1'h1, 8'h80);
        span(1'h1);
        chk("auto delay", 8'h01, n >= 28 && n <= 31);
        span(1'h0);
        chk("auto high", 8'h01, n >= 99 && n <= 101);
        idle(16);
        acc(1'h0, 1'h0, 8'hc1);
        idle(2);
        chk("restretch", 8'h01, scl_oe);
        acc(1'h1, 1'h1, 8'h00);
        idle(2);
        steady(150, 1'h0);
        chk("no auto", 8'h00, bad);
        acc(1'h0, 1'h0, 8'h81);
        acc(1'h0, 1'h1, 8'h80);
        span(1'h1);
        idle(12);
        // far side holds the pulse low
        bus_device_model_i.drive(1'h1, 1'h0);
        idle(60);
        bus_device_model_i.drive(1'h0, 1'h0);
        span(1'h0);
        chk("auto pause", 8'h01, n >= 80 && n <= 95);
        acc(1'h0, 1'h0, 8'hc1);
        idle(4);
        bus_device_model_i.stop_cond();
        idle(12);
        acc(1'h1, 1'h0, 8'h00);
        chk("busy after stop", 8'h00, rdv[4]);
        acc(1'h0, 1'h0, 8'hc0);
        bus_device_model_i.start_cond();
        idle(12);
        acc(1'h1, 1'h0, 8'h00);
        chk("busy off", 8'h00, rdv[4]);
        chk("start off", 8'h00, start_flag);
        chk("stretch off", 8'h00, scl_oe);
        bus_device_model_i.drive(1'h0, 1'h0);
        acc(1'h0, 1'h0, 8'h00);
        idle(2);
        steady(60, 1'h1);
        chk("ctrl no auto", 8'h00, bad);
        chk("sda pulled", 8'h01, sda_oe);
        chk("line drive", 8'h00, {scl_o, sda_o});
        tally_and_finish();
    end
endmodule : bit_bus_control_tb

/* File: verif/bus_device_model.sv */
// ****************************************
// far-side device on the two-wire bus
// ****************************************
module bus_device_model (
    // pulls from the block
    input wire logic i_scl_oe,
    input wire logic i_sda_oe,
    // wired line levels
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pull_scl = 1'h0;
    logic pull_sda = 1'h0;
    assign o_scl = !(i_scl_oe || pull_scl);
    assign o_sda = !(i_sda_oe || pull_sda);
    task automatic drive(input logic c, input logic d);
        pull_scl = c;
        pull_sda = d;
    endtask : drive
    task automatic start_cond();
        pull_sda = 1'h1;
        #320;
        pull_scl = 1'h1;
        #320;
    endtask : start_cond
    task automatic stop_cond();
        pull_scl = 1'h1;
        #320;
        pull_sda = 1'h1;
        #320;
        pull_scl = 1'h0;
        wait (o_scl);
        #320;
        pull_sda = 1'h0;
        #320;
    endtask : stop_cond
    task automatic send_bit(input logic b);
        pull_sda = !b;
        #320;
        pull_scl = 1'h0;
        wait (o_scl);
        #320;
        pull_scl = 1'h1;
        #320;
    endtask : send_bit
endmodule : bus_device_model
